// ===== core/store_lane_pkg.sv
// Shared types and constants of the store lane unit.
// Assumes one core clock and a synchronous active-high reset.
package store_lane_pkg;

    // ****************************************
    // Opcodes and fields
    // ****************************************
    localparam logic [5:0] OP_HALFWORD_STORE  = 6'h29;  // 101001
    localparam logic [5:0] OP_FP_EXTENDED     = 6'h13;  // 010011
    localparam logic [5:0] FN_INDEXED_FP_STORE = 6'h09; // 001001
    localparam logic [5:0] OP_COPROC_TWO_STORE = 6'h3e; // 111110
    localparam logic [5:0] OP_PARTIAL_LEFT    = 6'h2c;  // 101100
    localparam logic [5:0] OP_PARTIAL_RIGHT   = 6'h2d;  // 101101
    localparam int         OPC_POS            = 26;
    localparam int         IDX_ZERO_POS       = 6;
    localparam logic [2:0] DW_ALIGN_MASK      = 3'h7;
    localparam logic [2:0] HW_ALIGN_MASK      = 3'h1;
    localparam logic [7:0] LANES_NONE         = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        KIND_NONE    = 3'b000,
        KIND_CP2_DW  = 3'b001,
        KIND_LEFT    = 3'b010,
        KIND_RIGHT   = 3'b011,
        KIND_FPX_DW  = 3'b100,
        KIND_HALF    = 3'b101
    } store_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XLAT = 2'b01,
        ST_MEM  = 2'b10
    } stage_t;

    // Operands handed over by the issue stage
    typedef struct packed {
        logic [31:0] instr;
        logic [63:0] base_val;
        logic [63:0] index_val;
        logic [63:0] gpr_val;
        logic [63:0] cp2_val;
        logic [63:0] fpr_val;
        logic        cp1_usable;
        logic        cp2_usable;
    } store_req_t;

    // Exceptions a store can report
    typedef struct packed {
        logic addr_err;
        logic resv_instr;
        logic cop_unusable;
        logic tlb_refill;
        logic tlb_invalid;
        logic tlb_modified;
        logic bus_err;
    } store_exc_t;

    // Write handed to memory
    typedef struct packed {
        logic [63:0] addr;
        logic [7:0]  lanes;
        logic [63:0] data;
    } mem_write_t;

endpackage : store_lane_pkg

// ===== core/store_lane_placer.sv
// Byte lane placement for one store.
// Assumes a purely combinational context.
module store_lane_placer
(
    input  wire store_lane_pkg::store_kind_t kind,
    input  wire logic [2:0]                  k,
    input  wire logic                        big_endian,
    input  wire logic [63:0]                 src,
    output logic [7:0]                       lanes,
    output logic [63:0]                      data
);
    // Lane i is memory byte address i within the aligned doubleword
    always_comb
    begin
        lanes = store_lane_pkg::LANES_NONE;
        data  = 64'h0000_0000_0000_0000;
        for (int i = 0; i < 8; i++)
        begin
            // Memory byte at lane i is significance s (0 = least)
            automatic int s  = big_endian ? (7 - i) : i;
            automatic int kb = big_endian ? (7 - int'(k)) : int'(k);
            automatic int r  = 0;
            automatic logic on = 1'b0;
            case (kind)
                store_lane_pkg::KIND_LEFT:
                begin
                    // Top byte lands at k, lower ones descend
                    on = (s <= kb);
                    r  = s + 7 - kb; // RQ4 RQ5
                end
                store_lane_pkg::KIND_RIGHT:
                begin
                    // Lowest byte lands at k, higher ones ascend
                    on = (s >= kb);
                    r  = s - kb; // RQ6 RQ7
                end
                store_lane_pkg::KIND_HALF:
                begin
                    on = ((i >> 1) == (int'(k) >> 1));
                    r  = big_endian ? (1 - (i & 1)) : (i & 1); // RQ13
                end
                store_lane_pkg::KIND_NONE:
                begin
                    on = 1'b0;
                end
                default:
                begin
                    on = 1'b1;
                    r  = s;
                end
            endcase
            if (on && r >= 0 && r < 8)
            begin
                lanes[i]       = 1'b1;
                data[i*8 +: 8] = src[r*8 +: 8]; // RQ16
            end
        end
    end
endmodule : store_lane_placer

// ===== core/store_lane_unit.sv
// Store path of a 64-bit core: decode, address, alignment, lanes.
// Assumes a translation unit answering one request at a time and a
// memory write port with a ready handshake, all on clk.
// How it works
// RQ1: Coprocessor-2 doubleword store writes its 64-bit register at offset plus base.
// RQ2: Doubleword stores with nonzero address bits 2..0 raise address error, no write.
// RQ3: Coprocessor-2 store reports unusable, reserved, TLB faults and address error; the code never raises reserved for it.
// RQ4: Left partial store writes top register bytes within the aligned doubleword.
// RQ5: Left store puts top byte at offset k; byte order picks fill direction.
// RQ6: Right partial store writes bottom register bytes within the aligned doubleword.
// RQ7: Right store puts lowest byte at offset k; byte order picks fill direction.
// RQ8: Software pairs left and right stores to cover an unaligned doubleword.
// RQ9: Partial stores report TLB, bus, address and reserved faults; no alignment check. The code raises neither address nor reserved for them.
// RQ10: Indexed FP store uses base plus index and stores raw FPR content.
// RQ11: Indexed FP store decodes from opcode 010011, function 001001, zero bits 10..6.
// RQ12: Indexed FP store reports TLB faults, unusable, address and reserved faults.
// RQ13: Halfword store writes low 16 GPR bits at offset plus base.
// RQ14: Halfword store with odd address raises address error, no write.
// RQ15: Halfword store reports only TLB faults and address error; the code also passes on bus error from translation.
// RQ16: Stores go out as aligned address, byte lanes and lane-placed data.
// RQ17: Checks precede translation; any fault suppresses the memory write.
module store_lane_unit
(
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     req_valid,
    output logic                          req_ready,
    input  wire store_lane_pkg::store_req_t req,
    input  wire logic                     core_byte_order,
    input  wire logic                     user_byte_order_flip,
    output logic                          xlat_valid,
    output logic [63:0]                   xlat_vaddr,
    input  wire logic                     xlat_done,
    input  wire logic [63:0]              xlat_paddr,
    input  wire logic                     xlat_tlb_refill,
    input  wire logic                     xlat_tlb_invalid,
    input  wire logic                     xlat_tlb_modified,
    input  wire logic                     xlat_bus_err,
    output logic                          mem_valid,
    input  wire logic                     mem_ready,
    output store_lane_pkg::mem_write_t    mem_wr,
    output logic                          done_valid,
    output store_lane_pkg::store_exc_t    done_exc
);
    // ****************************************
    // Decode and address
    // ****************************************
    store_lane_pkg::store_kind_t kind;
    logic [63:0]                 eaddr;
    logic [63:0]                 src;
    logic [63:0]                 offs;
    store_lane_pkg::store_exc_t  early;
    logic [5:0]                  opc;
    logic                        big_endian;

    assign opc        = req.instr[31:store_lane_pkg::OPC_POS];
    assign offs       = {{48{req.instr[15]}}, req.instr[15:0]};
    assign big_endian = core_byte_order ^ user_byte_order_flip;

    // Classify instruction, form effective address, pick source
    always_comb
    begin
        kind  = store_lane_pkg::KIND_NONE;
        eaddr = req.base_val + offs; // RQ1 RQ13
        src   = req.gpr_val;
        early = '0;
        if (opc == store_lane_pkg::OP_COPROC_TWO_STORE)
        begin
            kind               = store_lane_pkg::KIND_CP2_DW;
            src                = req.cp2_val; // RQ1
            early.cop_unusable = !req.cp2_usable; // RQ3
            early.addr_err     = |(eaddr[2:0] & store_lane_pkg::DW_ALIGN_MASK); // RQ2
        end
        else if (opc == store_lane_pkg::OP_PARTIAL_LEFT)
        begin
            kind = store_lane_pkg::KIND_LEFT; // RQ9
        end
        else if (opc == store_lane_pkg::OP_PARTIAL_RIGHT)
        begin
            kind = store_lane_pkg::KIND_RIGHT; // RQ9
        end
        else if (opc == store_lane_pkg::OP_FP_EXTENDED)
        begin
            kind  = store_lane_pkg::KIND_FPX_DW;
            eaddr = req.base_val + req.index_val; // RQ10
            src   = req.fpr_val; // RQ10
            if (req.instr[5:0] != store_lane_pkg::FN_INDEXED_FP_STORE
                || req.instr[10:store_lane_pkg::IDX_ZERO_POS] != 5'h00)
            begin
                early.resv_instr = 1'b1; // RQ11 RQ12
            end
            else
            begin
                early.cop_unusable = !req.cp1_usable; // RQ12
                early.addr_err     = |(eaddr[2:0] & store_lane_pkg::DW_ALIGN_MASK); // RQ2
            end
        end
        else if (opc == store_lane_pkg::OP_HALFWORD_STORE)
        begin
            kind           = store_lane_pkg::KIND_HALF;
            early.addr_err = |(eaddr[2:0] & store_lane_pkg::HW_ALIGN_MASK); // RQ14 RQ15
        end
        else
        begin
            early.resv_instr = 1'b1;
        end
    end

    // ****************************************
    // Lane placement
    // ****************************************
    logic [7:0]  lanes;
    logic [63:0] placed;

    store_lane_placer u_placer
    (
        .kind       (kind),
        .k          (eaddr[2:0]),
        .big_endian (big_endian),
        .src        (src),
        .lanes      (lanes),
        .data       (placed)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    store_lane_pkg::stage_t     stage_q, stage_d;
    logic [63:0]                vaddr_q, vaddr_d;
    store_lane_pkg::mem_write_t wr_q, wr_d;
    logic                       dv_q, dv_d;
    store_lane_pkg::store_exc_t exc_q, exc_d;

    assign req_ready  = (stage_q == store_lane_pkg::ST_IDLE);
    assign xlat_valid = (stage_q == store_lane_pkg::ST_XLAT);
    assign xlat_vaddr = vaddr_q;
    assign mem_valid  = (stage_q == store_lane_pkg::ST_MEM);
    assign mem_wr     = wr_q;
    assign done_valid = dv_q;
    assign done_exc   = exc_q;

    // Next state: check, translate, then write
    always_comb
    begin
        stage_d = stage_q;
        vaddr_d = vaddr_q;
        wr_d    = wr_q;
        dv_d    = 1'b0;
        exc_d   = exc_q;
        case (stage_q)
            store_lane_pkg::ST_IDLE:
            begin
                if (req_valid)
                begin
                    exc_d = early;
                    if (|early)
                    begin
                        dv_d = 1'b1; // RQ17
                    end
                    else
                    begin
                        vaddr_d       = eaddr;
                        wr_d.lanes    = lanes;
                        wr_d.data     = placed;
                        stage_d       = store_lane_pkg::ST_XLAT;
                    end
                end
            end
            store_lane_pkg::ST_XLAT:
            begin
                if (xlat_done)
                begin
                    exc_d.tlb_refill   = xlat_tlb_refill;
                    exc_d.tlb_invalid  = xlat_tlb_invalid;
                    exc_d.tlb_modified = xlat_tlb_modified;
                    exc_d.bus_err      = xlat_bus_err;
                    wr_d.addr          = {xlat_paddr[63:3], 3'h0}; // RQ16
                    if (xlat_tlb_refill | xlat_tlb_invalid | xlat_tlb_modified | xlat_bus_err)
                    begin
                        dv_d    = 1'b1; // RQ17
                        stage_d = store_lane_pkg::ST_IDLE;
                    end
                    else
                    begin
                        stage_d = store_lane_pkg::ST_MEM;
                    end
                end
            end
            store_lane_pkg::ST_MEM:
            begin
                if (mem_ready)
                begin
                    dv_d    = 1'b1;
                    stage_d = store_lane_pkg::ST_IDLE;
                end
            end
            default:
            begin
                stage_d = store_lane_pkg::ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stage_q <= store_lane_pkg::ST_IDLE;
            vaddr_q <= 64'h0000_0000_0000_0000;
            wr_q    <= '0;
            dv_q    <= 1'b0;
            exc_q   <= '0;
        end
        else
        begin
            stage_q <= stage_d;
            vaddr_q <= vaddr_d;
            wr_q    <= wr_d;
            dv_q    <= dv_d;
            exc_q   <= exc_d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_NO_WRITE_ON_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && |early |=> !xlat_valid && done_valid) // RQ17
        else $error("Faulting store went on to translation");
    AST_DW_ALIGN: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && (kind == store_lane_pkg::KIND_CP2_DW)
        && eaddr[2:0] != 3'h0 |=> done_exc.addr_err) // RQ2
        else $error("Misaligned doubleword store not flagged");
    AST_HALF_ALIGN: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && (kind == store_lane_pkg::KIND_HALF)
        |=> done_exc.addr_err == $past(eaddr[0])) // RQ14
        else $error("Halfword alignment check wrong");
    AST_HALF_FAULTS: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && (kind == store_lane_pkg::KIND_HALF)
        |=> !done_exc.cop_unusable && !done_exc.resv_instr) // RQ15
        else $error("Halfword store raised a foreign exception");
    AST_PARTIAL_NOALIGN: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && (kind inside {store_lane_pkg::KIND_LEFT,
        store_lane_pkg::KIND_RIGHT}) |=> xlat_valid) // RQ9
        else $error("Partial store did not reach translation");
    AST_FPX_DECODE: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && opc == store_lane_pkg::OP_FP_EXTENDED
        && req.instr[10:6] != 5'h00 |=> done_valid && done_exc.resv_instr) // RQ11
        else $error("Nonzero field of indexed store not refused");
    AST_CP2_UNUSABLE: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && (kind == store_lane_pkg::KIND_CP2_DW)
        && !req.cp2_usable |=> done_exc.cop_unusable) // RQ3
        else $error("Coprocessor unusable not raised");
    AST_ALIGNED_OUT: assert property (@(posedge clk) disable iff (sys_rst)
        mem_valid |-> mem_wr.addr[2:0] == 3'h0 && mem_wr.lanes != 8'h00) // RQ16
        else $error("Memory write not aligned or empty");
    AST_LEFT_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && kind == store_lane_pkg::KIND_LEFT && !big_endian
        |=> $countones(wr_q.lanes) == int'($past(eaddr[2:0])) + 1) // RQ5
        else $error("Left store lane count wrong");
    AST_RIGHT_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && kind == store_lane_pkg::KIND_RIGHT && big_endian
        |=> $countones(wr_q.lanes) == int'($past(eaddr[2:0])) + 1) // RQ7
        else $error("Right store lane count wrong");

endmodule : store_lane_unit

// ===== sim/store_lane_unit_tb_top.sv
// Self-checking bench of the store lane unit, one task per scenario.
// Assumes the package under core/ and the far-side model xlat_mem_model.
module store_lane_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Harness
    // ****************************************
    logic        clk, sys_rst, req_valid, req_ready, core_byte_order, user_byte_order_flip;
    logic        xlat_valid, xlat_done, mem_valid, mem_ready, done_valid;
    logic        s_cp1, s_cp2, s_big, s_flip;
    logic [1:0]  slow;
    logic [3:0]  fault_sel, fault;
    logic [7:0]  wr_count, got_n;
    logic [63:0] xlat_vaddr, xlat_paddr;
    int          bad_count, n_tests, cyc;
    store_lane_pkg::store_req_t req;
    store_lane_pkg::mem_write_t mem_wr, last_wr;
    store_lane_pkg::store_exc_t done_exc, got_exc;

    store_lane_unit u_dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .core_byte_order(core_byte_order),
        .user_byte_order_flip(user_byte_order_flip), .xlat_valid(xlat_valid),
        .xlat_vaddr(xlat_vaddr), .xlat_done(xlat_done), .xlat_paddr(xlat_paddr),
        .xlat_tlb_refill(fault[3]), .xlat_tlb_invalid(fault[2]), .xlat_tlb_modified(fault[1]),
        .xlat_bus_err(fault[0]), .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_wr(mem_wr),
        .done_valid(done_valid), .done_exc(done_exc));

    xlat_mem_model u_far (.clk(clk), .sys_rst(sys_rst), .slow(slow), .fault_sel(fault_sel),
        .xlat_valid(xlat_valid), .xlat_vaddr(xlat_vaddr), .xlat_done(xlat_done),
        .xlat_paddr(xlat_paddr), .xlat_fault(fault), .mem_valid(mem_valid),
        .mem_ready(mem_ready), .mem_wr(mem_wr), .wr_count(wr_count), .last_wr(last_wr));

    // Clock of 100 ns
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Cuts a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end

    // ****************************************
    // Checks and transfers
    // ****************************************
    task automatic tally(input logic [135:0] got, input logic [135:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : tally

    task automatic cmp_exc(input store_lane_pkg::store_exc_t got, input logic [6:0] exp);
        tally(136'(got), 136'(exp));
    endtask : cmp_exc

    task automatic cmp_n(input logic [7:0] got, input logic [7:0] exp);
        tally(136'(got), 136'(exp));
    endtask : cmp_n

    // Only enabled lanes carry meaning in the data
    task automatic cmp_wr(input store_lane_pkg::mem_write_t got,
                          input store_lane_pkg::mem_write_t exp);
        logic [63:0] m;
        for (int i = 0; i < 8; i++)
            m[8*i+:8] = {8{exp.lanes[i]}};
        got.data = got.data & m;
        exp.data = exp.data & m;
        tally(got, exp);
    endtask : cmp_wr

    // One store: offer, release after taken, wait for the done pulse
    task automatic go(input logic [31:0] ins, input logic [63:0] b, input logic [63:0] x,
                      input logic [6:0] ex, input logic [7:0] en);
        logic [7:0] w0;
        int         t;
        w0 = wr_count;
        t = 0;
        @(posedge clk);
        req.instr            <= ins;
        req.base_val         <= b;
        req.index_val        <= x;
        req.cp1_usable       <= s_cp1;
        req.cp2_usable       <= s_cp2;
        core_byte_order      <= s_big;
        user_byte_order_flip <= s_flip;
        req_valid            <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        do
        begin
            @(negedge clk);
            t++;
        end
        while (done_valid !== 1'b1 && t < 200);
        got_n = wr_count - w0;
        cmp_n(8'({done_valid, req_ready}), 8'h03);
        cmp_exc(done_exc, ex);
        cmp_n(got_n, en);
    endtask : go

    // Doubleword as lanes hold it: in big endian the top byte sits at lane 0
    function automatic logic [63:0] lane_dw(input logic b, input logic [63:0] v);
        logic [63:0] o;
        for (int i = 0; i < 8; i++)
            o[8*i+:8] = b ? v[56-8*i+:8] : v[8*i+:8];
        return o;
    endfunction : lane_dw

    // Lanes and data expected of a partial store at offset k
    function automatic store_lane_pkg::mem_write_t part(input logic r, input logic b,
                                                        input int k, input logic [63:0] a);
        store_lane_pkg::mem_write_t w;
        int                         s;
        w = '{addr: {a[63:3], 3'h0}, lanes: 8'h00, data: 64'h0};
        for (int i = 0; i < 8; i++)
            if (r ? (b ? i <= k : i >= k) : (b ? i >= k : i <= k))
            begin
                s = r ? (b ? k - i : i - k) : (b ? 7 - i + k : 7 - k + i);
                w.lanes[i] = 1'b1;
                w.data[8*i+:8] = req.gpr_val[8*s+:8];
            end
        return w;
    endfunction : part

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_cp2();
        logic [31:0] ok;
        ok = {store_lane_pkg::OP_COPROC_TWO_STORE, 10'h022, 16'hfff8};
        slow = 2'h2;
        go(ok, 64'h0000_0000_0000_1000, 64'h0, 7'h00, 8'h01);
        cmp_wr(last_wr, '{64'h0000_0000_0000_0ff8, 8'hff,
                          lane_dw(s_big ^ s_flip, req.cp2_val)});
        go({ok[31:16], 16'h0004}, 64'h0000_0000_0000_1000, 64'h0, 7'h40, 8'h00);
        s_cp2 = 1'b0;
        go(ok, 64'h0000_0000_0000_1000, 64'h0, 7'h10, 8'h00);
        s_cp2 = 1'b1;
        for (int j = 2; j < 16; j = j * 2)
        begin
            fault_sel = 4'(j);
            go(ok, 64'h0000_0000_0000_1000, 64'h0, 7'(j), 8'h00);
        end
        fault_sel = 4'h0;
        $display("coprocessor store test done");
    endtask : t_cp2

    task automatic t_part();
        logic [5:0] op;
        logic [7:0] n;
        for (int r = 0; r < 2; r++)
            for (int b = 0; b < 2; b++)
                for (int k = 0; k < 8; k++)
                begin
                    op = r ? store_lane_pkg::OP_PARTIAL_RIGHT : store_lane_pkg::OP_PARTIAL_LEFT;
                    s_big = b[0] ^ k[0];
                    s_flip = k[0];
                    slow = k[1:0];
                    go({op, 10'h022, 16'hfff0}, 64'h2010 + k, 64'h0, 7'h00, 8'h01);
                    cmp_wr(last_wr, part(r[0], b[0], k, 64'h2000 + k));
                end
        s_big = 1'b1;
        s_flip = 1'b0;
        go({store_lane_pkg::OP_PARTIAL_LEFT, 26'h0}, 64'h2002, 64'h0, 7'h00, 8'h01);
        n = 8'($countones(last_wr.lanes));
        go({store_lane_pkg::OP_PARTIAL_RIGHT, 26'h0}, 64'h2009, 64'h0, 7'h00, 8'h01);
        cmp_n(n + 8'($countones(last_wr.lanes)), 8'h08);
        fault_sel = 4'h1;
        go({store_lane_pkg::OP_PARTIAL_LEFT, 26'h0}, 64'h2003, 64'h0, 7'h01, 8'h00);
        fault_sel = 4'h0;
        $display("partial store test done");
    endtask : t_part

    task automatic t_fpx();
        logic [31:0] ok;
        ok = {store_lane_pkg::OP_FP_EXTENDED, 20'h0_4180, store_lane_pkg::FN_INDEXED_FP_STORE};
        go(ok, 64'h3000, 64'h0018, 7'h00, 8'h01);
        cmp_wr(last_wr, '{64'h3018, 8'hff, lane_dw(s_big ^ s_flip, req.fpr_val)});
        go(ok, 64'h3000, 64'h001c, 7'h40, 8'h00);
        go(ok | 32'h0000_0100, 64'h3000, 64'h0018, 7'h20, 8'h00);
        go({6'h00, 26'h0}, 64'h3000, 64'h0018, 7'h20, 8'h00);
        s_cp1 = 1'b0;
        go(ok, 64'h3000, 64'h0018, 7'h10, 8'h00);
        s_cp1 = 1'b1;
        fault_sel = 4'h2;
        go(ok, 64'h3000, 64'h0018, 7'h02, 8'h00);
        fault_sel = 4'h0;
        $display("indexed store test done");
    endtask : t_fpx

    task automatic t_half();
        logic [31:0]                ok;
        store_lane_pkg::mem_write_t e;
        ok = {store_lane_pkg::OP_HALFWORD_STORE, 10'h022, 16'h0002};
        s_cp1 = 1'b0;
        s_cp2 = 1'b0;
        for (int b = 0; b < 2; b++)
            for (int j = 0; j < 4; j++)
            begin
                s_big = b[0];
                e = '{addr: 64'h4000, lanes: 8'h03 << (2 * j), data: 64'h0};
                e.data[16*j+:16] = b ? {req.gpr_val[7:0], req.gpr_val[15:8]} : req.gpr_val[15:0];
                go(ok, 64'h3ffe + 2 * j, 64'h0, 7'h00, 8'h01);
                cmp_wr(last_wr, e);
            end
        go(ok, 64'h3fff, 64'h0, 7'h40, 8'h00);
        fault_sel = 4'h4;
        go(ok, 64'h3ffe, 64'h0, 7'h04, 8'h00);
        fault_sel = 4'h0;
        s_cp1 = 1'b1;
        s_cp2 = 1'b1;
        $display("halfword store test done");
    endtask : t_half

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial
    begin
        bad_count = 0;
        n_tests = 0;
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        req.gpr_val = 64'h8877_6655_4433_2211;
        req.cp2_val = 64'hc2c1_b2b1_a2a1_9291;
        req.fpr_val = 64'hf8f7_e6e5_d4d3_c2c1;
        core_byte_order = 1'b1;
        user_byte_order_flip = 1'b0;
        {s_cp1, s_cp2, s_big, s_flip} = 4'hE;
        slow = 2'h0;
        fault_sel = 4'h0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_cp2();
        t_part();
        t_fpx();
        t_half();
        report_and_stop();
    end
endmodule : store_lane_unit_tb_top

// ===== sim/xlat_mem_model.sv
// Behavioural translation and memory path facing the store lane unit.
// Assumes the unit's clk and sys_rst; translation is identity, delay is set by the bench.
module xlat_mem_model
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic [1:0]                 slow,
    input  wire logic [3:0]                 fault_sel,
    input  wire logic                       xlat_valid,
    input  wire logic [63:0]                xlat_vaddr,
    output logic                            xlat_done,
    output logic [63:0]                     xlat_paddr,
    output logic [3:0]                      xlat_fault,
    input  wire logic                       mem_valid,
    output logic                            mem_ready,
    input  wire store_lane_pkg::mem_write_t mem_wr,
    output logic [7:0]                      wr_count,
    output store_lane_pkg::mem_write_t      last_wr
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Answer logic
    // ****************************************
    logic [1:0] wait_q;

    // Answers after slow cycles; address lines toggle whenever no answer stands
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            xlat_done  <= 1'b0;
            xlat_paddr <= 64'h0;
            xlat_fault <= 4'h0;
            mem_ready  <= 1'b0;
            wait_q     <= 2'h0;
            wr_count   <= 8'h00;
            last_wr    <= '0;
        end
        else
        begin
            xlat_done  <= 1'b0;
            xlat_paddr <= ~xlat_paddr;
            xlat_fault <= 4'h0;
            mem_ready  <= 1'b0;
            wait_q     <= wait_q + 2'h1;
            if (xlat_valid && !xlat_done && wait_q == slow)
            begin
                xlat_done  <= 1'b1;
                xlat_paddr <= xlat_vaddr;
                xlat_fault <= fault_sel;
            end
            if (mem_valid && !mem_ready && wait_q == slow)
                mem_ready <= 1'b1;
            if (mem_valid && mem_ready)
            begin
                wr_count <= wr_count + 8'h01;  // Only taken writes count
                last_wr  <= mem_wr;
            end
            if (!(xlat_valid && !xlat_done) && !(mem_valid && !mem_ready) || wait_q == slow)
                wait_q <= 2'h0;
        end
    end
endmodule : xlat_mem_model
